// ==== logic/alr_link_alarm_raw.sv ====
// file: sticky raw alarm status for six links plus shared bits, AXI4-Lite slave
// Summary of operation
// - link raw a bit 24 sets on decoder timestamp fault (OBSAI)
// - link raw a bit 20 sets on unexpected boundary at input converter (CPRI)
// - link raw a bit 16 sets on serializer loss of signal
// - bit 15 sets on receiver state 0 or 1; bit 14 while in state 3
// - control word Z.130.0 b4..b0 map onto raw a bits 13 down to 9
// - raw a bit 8 sets when an OBSAI idle K30.7 character is received
// - raw a bit 7 sets when master frame boundary falls outside valid window
// - bit 6 on missing frame marker in ST3; bit 5 on missing OBSAI comma
// - bit 4 on block/hyperframe edge; bit 3 on master frame edge
// - bit 2 on any 8b10b decode error; bit 1 at signal loss limit
// - raw a bit 0 sets on receive sync state change
// - six copies of raw a and raw b, one pair per link
// - raw b bit 24 sets when encoder control word lacks k28.5
// - raw b bits 20 to 16 flag circuit switch DMA under and overruns
// - raw b bit 10 sum overrun, bit 9 alignment fault, bit 8 header fault
// - raw b bit 3 sets when transmit queue overruns
// - raw b bit 2 payload misaligned, bit 1 frame strobe misaligned
// - raw b bit 0 sets when transmit state machine changes state
// - shared bit 25 illegal packet write, bit 24 capture half read fault
// - shared bits 23 to 20 flag bus side debug accesses
// - shared bit 19 pointer wrap, 18 list fault, 17/16 OBSAI access errors
// - shared bits 15..12 DMA underflow, 11..8 overflow, FIFOs 3 down to 0
// - writing 1 to a raw register bit sets that bit for diagnostics
// - masked status reads raw AND mask
// - an event in the clear cycle keeps the bit set
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
module alr_link_alarm_raw (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// per link event pulses in raw a layout (bit n of word = raw a bit n)
	input wire logic [31:0] LINK_RAW_A_EVT [6],
	input wire logic [31:0] LINK_RAW_B_EVT [6],
	input wire logic [31:0] SHARED_RAW_EVT,
	// AXI4-Lite
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	typedef struct packed {
		logic [alr_pkg::NUM_REGS-1:0][31:0] raw;
		logic [alr_pkg::NUM_REGS-1:0][31:0] mask;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} alr_state_s;

	alr_state_s st_q;
	alr_state_s st_d;

	// event vectors gathered by register index: 0..5 raw a, 6..11 raw b, 12 shared
	logic [alr_pkg::NUM_REGS-1:0][31:0] evt;
	logic [alr_pkg::NUM_REGS-1:0][31:0] impl;
	genvar gi;
	generate
		for (gi = 0; gi < alr_pkg::NUM_LINKS; gi++) begin : g_link
			// one pair of raw registers per link
			assign evt[gi] = LINK_RAW_A_EVT[gi] & alr_pkg::RAW_A_MASK;
			assign evt[gi+6] = LINK_RAW_B_EVT[gi] & alr_pkg::RAW_B_MASK;
			assign impl[gi] = alr_pkg::RAW_A_MASK;
			assign impl[gi+6] = alr_pkg::RAW_B_MASK;
		end
	endgenerate
	assign evt[12] = SHARED_RAW_EVT & alr_pkg::SHARED_MASK;
	assign impl[12] = alr_pkg::SHARED_MASK;

	// address decode: returns bank (0 raw,1 masked,2 set,3 clr), index, hit
	function automatic logic [6:0] decode(input logic [7:0] a);
		logic [7:0] ofs;
		logic [1:0] bank;
		logic [3:0] idx;
		logic hit;
		bank = a[7:6];
		ofs = {2'b00, a[5:0]};
		idx = 4'h0;
		hit = 1'b0;
		if (a[1:0] == 2'b00) begin
			if (ofs == alr_pkg::SHARED_RAW_OFS) begin
				idx = 4'hC;
				hit = 1'b1;
			end else if (ofs < alr_pkg::SHARED_RAW_OFS) begin
				idx = 4'(ofs[5:3]) + ((ofs[2]) ? 4'h6 : 4'h0);
				hit = 1'b1;
			end
		end
		return {bank, idx, hit};
	endfunction

	logic [6:0] wdec;
	logic [6:0] rdec;
	logic [31:0] wmask;
	logic do_write;
	logic do_read;
	assign wdec = decode(st_q.awaddr);
	assign rdec = decode(S_AXI_ARADDR);
	assign wmask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
	assign do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign do_read = S_AXI_ARVALID && !st_q.rvalid;

	// handshake outputs: address and data each taken once, held until response
	assign S_AXI_AWREADY = !st_q.aw_got && !st_q.bvalid;
	assign S_AXI_WREADY = !st_q.w_got && !st_q.bvalid;
	assign S_AXI_ARREADY = !st_q.rvalid;
	assign S_AXI_BVALID = st_q.bvalid;
	assign S_AXI_BRESP = st_q.bresp;
	assign S_AXI_RVALID = st_q.rvalid;
	assign S_AXI_RDATA = st_q.rdata;
	assign S_AXI_RRESP = st_q.rresp;

	// next state: sticky raw bits, bus write effects, read mux
	always_comb begin
		logic [31:0] wv;
		logic [31:0] clr;
		logic [31:0] rv;
		st_d = st_q;
		wv = st_q.wdata & wmask;
		clr = 32'h00000000;
		rv = 32'h00000000;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			st_d.w_got = 1'b1;
			st_d.wdata = S_AXI_WDATA;
			st_d.wstrb = S_AXI_WSTRB;
		end
		for (int i = 0; i < alr_pkg::NUM_REGS; i++) begin
			clr = 32'h00000000;
			if (do_write && wdec[0] && wdec[4:1] == 4'(i)) begin
				unique case (wdec[6:5])
					2'b00: st_d.raw[i] = st_q.raw[i] | (wv & impl[i]);
					2'b01: clr = wv & impl[i]; // write 1 to masked clears raw
					2'b10: st_d.mask[i] = st_q.mask[i] | (wv & impl[i]);
					2'b11: st_d.mask[i] = st_q.mask[i] & ~wv;
				endcase
			end
			// set wins over clear so no event is lost
			st_d.raw[i] = ((st_d.raw[i] & ~clr) | evt[i]) & impl[i];
		end
		if (do_write) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wdec[0] ? alr_pkg::RESP_OKAY : alr_pkg::RESP_SLVERR;
		end else if (st_q.bvalid && S_AXI_BREADY) begin
			st_d.bvalid = 1'b0;
		end
		if (rdec[0]) begin
			unique case (rdec[6:5])
				2'b00: rv = st_q.raw[rdec[4:1]];
				2'b01: rv = st_q.raw[rdec[4:1]] & st_q.mask[rdec[4:1]];
				default: rv = st_q.mask[rdec[4:1]];
			endcase
		end
		if (do_read) begin
			st_d.rvalid = 1'b1;
			st_d.rdata = rv;
			st_d.rresp = rdec[0] ? alr_pkg::RESP_OKAY : alr_pkg::RESP_SLVERR;
		end else if (st_q.rvalid && S_AXI_RREADY) begin
			st_d.rvalid = 1'b0;
		end
	end

	// one register for the whole state; all flags clear at reset
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// checks on the sticky bits
	property p_raw_a_sets;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[0][24] |=> st_q.raw[0][24];
	endproperty
	a_raw_a_sets: assert property (p_raw_a_sets) else $error("raw a bit 24 not set");

	property p_raw_a_bnd;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[5][7] |=> st_q.raw[5][7];
	endproperty
	a_raw_a_bnd: assert property (p_raw_a_bnd) else $error("raw a bit 7 link 5 not set");

	property p_raw_b_sets;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[3][0] |=> st_q.raw[9][0];
	endproperty
	a_raw_b_sets: assert property (p_raw_b_sets) else $error("raw b bit 0 link 3 not set");

	property p_shared_sets;
		@(posedge CORE_CLK) disable iff (!RSTN)
		SHARED_RAW_EVT[15] |=> st_q.raw[12][15];
	endproperty
	a_shared_sets: assert property (p_shared_sets) else $error("shared bit 15 not set");

	property p_reserved_zero;
		@(posedge CORE_CLK) disable iff (!RSTN)
		(st_q.raw[0] & ~alr_pkg::RAW_A_MASK) == 32'h00000000 && (st_q.raw[12] & ~alr_pkg::SHARED_MASK) == 32'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved raw bit set");

	property p_sticky;
		@(posedge CORE_CLK) disable iff (!RSTN)
		st_q.raw[6][3] && !(do_write && wdec[6:5] == 2'b01) |=> st_q.raw[6][3];
	endproperty
	a_sticky: assert property (p_sticky) else $error("raw bit dropped without clear");

	property p_set_wins;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[1][3] && do_write |=> st_q.raw[7][3];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost in clear cycle");

	property p_masked_read;
		@(posedge CORE_CLK) disable iff (!RSTN)
		do_read && rdec[0] && rdec[6:5] == 2'b01 |=> S_AXI_RVALID && (S_AXI_RDATA & ~$past(st_q.mask[rdec[4:1]])) == 32'h0;
	endproperty
	a_masked_read: assert property (p_masked_read) else $error("masked read shows unmasked bit");

	property p_raw_a_boundary;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[1][20] |=> st_q.raw[1][20];
	endproperty
	a_raw_a_boundary: assert property (p_raw_a_boundary) else $error("raw a bit 20 link 1 not set");

	property p_raw_a_los;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[2][16] |=> st_q.raw[2][16];
	endproperty
	a_raw_a_los: assert property (p_raw_a_los) else $error("raw a bit 16 link 2 not set");

	property p_raw_a_states;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[3][15:14] != 2'h0 |=> (st_q.raw[3][15:14] | ~$past(LINK_RAW_A_EVT[3][15:14])) == 2'h3;
	endproperty
	a_raw_a_states: assert property (p_raw_a_states) else $error("raw a bits 15..14 link 3 not set");

	property p_raw_a_remote;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[4][13:9] != 5'h00 |=> (st_q.raw[4][13:9] | ~$past(LINK_RAW_A_EVT[4][13:9])) == 5'h1F;
	endproperty
	a_raw_a_remote: assert property (p_raw_a_remote) else $error("raw a bits 13..9 link 4 not set");

	property p_raw_a_idle;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[5][8] |=> st_q.raw[5][8];
	endproperty
	a_raw_a_idle: assert property (p_raw_a_idle) else $error("raw a bit 8 link 5 not set");

	property p_raw_a_marker;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[0][6:5] != 2'h0 |=> (st_q.raw[0][6:5] | ~$past(LINK_RAW_A_EVT[0][6:5])) == 2'h3;
	endproperty
	a_raw_a_marker: assert property (p_raw_a_marker) else $error("raw a bits 6..5 link 0 not set");

	property p_raw_a_edges;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[1][4:3] != 2'h0 |=> (st_q.raw[1][4:3] | ~$past(LINK_RAW_A_EVT[1][4:3])) == 2'h3;
	endproperty
	a_raw_a_edges: assert property (p_raw_a_edges) else $error("raw a bits 4..3 link 1 not set");

	property p_raw_a_line;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[2][2:1] != 2'h0 |=> (st_q.raw[2][2:1] | ~$past(LINK_RAW_A_EVT[2][2:1])) == 2'h3;
	endproperty
	a_raw_a_line: assert property (p_raw_a_line) else $error("raw a bits 2..1 link 2 not set");

	property p_raw_a_sync;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_A_EVT[3][0] |=> st_q.raw[3][0];
	endproperty
	a_raw_a_sync: assert property (p_raw_a_sync) else $error("raw a bit 0 link 3 not set");

	property p_raw_b_cword;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[1][24] |=> st_q.raw[7][24];
	endproperty
	a_raw_b_cword: assert property (p_raw_b_cword) else $error("raw b bit 24 link 1 not set");

	property p_raw_b_dma;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[0][20:16] != 5'h00 |=> (st_q.raw[6][20:16] | ~$past(LINK_RAW_B_EVT[0][20:16])) == 5'h1F;
	endproperty
	a_raw_b_dma: assert property (p_raw_b_dma) else $error("raw b bits 20..16 link 0 not set");

	property p_raw_b_aggr;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[2][10:8] != 3'h0 |=> (st_q.raw[8][10:8] | ~$past(LINK_RAW_B_EVT[2][10:8])) == 3'h7;
	endproperty
	a_raw_b_aggr: assert property (p_raw_b_aggr) else $error("raw b bits 10..8 link 2 not set");

	property p_raw_b_queue;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[4][3] |=> st_q.raw[10][3];
	endproperty
	a_raw_b_queue: assert property (p_raw_b_queue) else $error("raw b bit 3 link 4 not set");

	property p_raw_b_align;
		@(posedge CORE_CLK) disable iff (!RSTN)
		LINK_RAW_B_EVT[5][2:1] != 2'h0 |=> (st_q.raw[11][2:1] | ~$past(LINK_RAW_B_EVT[5][2:1])) == 2'h3;
	endproperty
	a_raw_b_align: assert property (p_raw_b_align) else $error("raw b bits 2..1 link 5 not set");

	property p_shared_buf;
		@(posedge CORE_CLK) disable iff (!RSTN)
		SHARED_RAW_EVT[25:24] != 2'h0 |=> (st_q.raw[12][25:24] | ~$past(SHARED_RAW_EVT[25:24])) == 2'h3;
	endproperty
	a_shared_buf: assert property (p_shared_buf) else $error("shared bits 25..24 not set");

	property p_shared_debug;
		@(posedge CORE_CLK) disable iff (!RSTN)
		SHARED_RAW_EVT[23:20] != 4'h0 |=> (st_q.raw[12][23:20] | ~$past(SHARED_RAW_EVT[23:20])) == 4'hF;
	endproperty
	a_shared_debug: assert property (p_shared_debug) else $error("shared bits 23..20 not set");

	property p_shared_list;
		@(posedge CORE_CLK) disable iff (!RSTN)
		SHARED_RAW_EVT[19:16] != 4'h0 |=> (st_q.raw[12][19:16] | ~$past(SHARED_RAW_EVT[19:16])) == 4'hF;
	endproperty
	a_shared_list: assert property (p_shared_list) else $error("shared bits 19..16 not set");

	// a masked write of 1 with no event pending must drop the raw bit
	property p_clear_works;
		@(posedge CORE_CLK) disable iff (!RSTN)
		do_write && wdec[0] && wdec[6:5] == 2'h1 && wdec[4:1] == 4'h7 && st_q.wstrb[2] && st_q.wdata[16]
			&& !LINK_RAW_B_EVT[1][16] |=> !st_q.raw[7][16];
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("masked write did not clear raw bit");

	property p_diag_set;
		@(posedge CORE_CLK) disable iff (!RSTN)
		do_write && wdec[0] && wdec[6:5] == 2'h0 && wdec[4:1] == 4'hC && st_q.wstrb[1] && st_q.wdata[8]
			|=> st_q.raw[12][8];
	endproperty
	a_diag_set: assert property (p_diag_set) else $error("diagnostic write did not set raw bit");
endmodule

// ==== logic/alr_pkg.sv ====
// package: register map, field masks and widths for the link alarm raw status block
package alr_pkg;
	localparam int NUM_LINKS = 6;
	localparam int ADDR_W = 8;
	// per link: raw a at LINK_BASE + 8*link, raw b at +4; shared raw after the links
	localparam logic [7:0] LINK_BASE = 8'h00;
	localparam logic [7:0] LINK_STRIDE = 8'h08;
	localparam logic [7:0] RAW_B_OFS = 8'h04;
	localparam logic [7:0] SHARED_RAW_OFS = 8'h30;
	// masked status and mask set/clear, same layout shifted by a block base
	localparam logic [7:0] MASKED_BASE = 8'h40;
	localparam logic [7:0] MASK_SET_BASE = 8'h80;
	localparam logic [7:0] MASK_CLR_BASE = 8'hC0;
	// implemented (non reserved) bits of each register
	localparam logic [31:0] RAW_A_MASK = 32'h1F11FFFF;
	localparam logic [31:0] RAW_B_MASK = 32'h011F370F;
	localparam logic [31:0] SHARED_MASK = 32'h03FFFF03;
	localparam logic [31:0] RAW_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	// number of registers in a bank: 6 a, 6 b, 1 shared
	localparam int NUM_REGS = 13;
	localparam int REG_IDX_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// master frame window, printed typical figure, as a cycle count at 125 MHz
	localparam int CLK_PERIOD_NS = 8;
	localparam int BNDY_WINDOW_NS = 65;
	localparam int BNDY_WINDOW_CYC = BNDY_WINDOW_NS / CLK_PERIOD_NS;
endpackage

// ==== verif/alr_evt_src.sv ====
// event source model: link sub-units pulsing alarm conditions
module alr_evt_src (
	input wire logic en,
	input wire logic [3:0] idx,
	input wire logic [31:0] bits,
	output logic [31:0] link_a [6],
	output logic [31:0] link_b [6],
	output logic [31:0] shared_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	// only the addressed register sees the request, all other lines stay quiet
	always_comb begin
		for (int l = 0; l < 6; l++) begin
			link_a[l] = (en && idx == 4'(2 * l)) ? bits : 32'h00000000;
			link_b[l] = (en && idx == 4'(2 * l + 1)) ? bits : 32'h00000000;
		end
		shared_evt = (en && idx == 4'hC) ? bits : 32'h00000000;
	end
endmodule

// ==== verif/alr_link_alarm_raw_test.sv ====
// self-checking bench for the link alarm raw status block
module alr_link_alarm_raw_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, en = 1'b0;
	logic [3:0] idx = 4'h0;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] bits = 32'h00000000, wdata = 32'h00000000, rdata, r, mk [13], ex [13];
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] ea [6], eb [6], es;
	logic [1:0] exp_b [$];
	logic [33:0] exp_r [$];
	int mismatches = 0, checks = 0;
	// core clock, 8 ns
	always #4 clk = ~clk;
	alr_evt_src src (.en(en), .idx(idx), .bits(bits), .link_a(ea), .link_b(eb), .shared_evt(es));
	alr_link_alarm_raw dut (.CORE_CLK(clk), .RSTN(rstn), .LINK_RAW_A_EVT(ea), .LINK_RAW_B_EVT(eb),
		.SHARED_RAW_EVT(es), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	// implemented bits: index 12 is shared, odd is raw b, even raw a
	function automatic logic [31:0] msk(int i);
		return i == 12 ? alr_pkg::SHARED_MASK : (i % 2 ? alr_pkg::RAW_B_MASK : alr_pkg::RAW_A_MASK);
	endfunction
	task automatic cmp_resp(logic [1:0] e, logic [1:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH bresp expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_read(logic [33:0] e, logic [33:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH rresp_rdata expected %h seen %h", e, s);
		end
	endtask
	// write: address and data together, each released once taken
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e = alr_pkg::RESP_OKAY, logic [3:0] s = 4'hF);
		@(posedge clk);
		exp_b.push_back(e);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] e = alr_pkg::RESP_OKAY);
		@(posedge clk);
		exp_r.push_back({e, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	// one-cycle condition pulse into register i
	task automatic fire(int i, logic [31:0] b);
		@(posedge clk);
		idx <= 4'(i);
		bits <= b;
		en <= 1'b1;
		@(posedge clk);
		en <= 1'b0;
		ex[i] |= b & msk(i);
	endtask
	// response watcher: oldest note against each answer
	always @(posedge clk) begin
		if (bvalid && bready) cmp_resp(exp_b.pop_front(), bresp);
		if (rvalid && rready) cmp_read(exp_r.pop_front(), {rresp, rdata});
	end
	task automatic results();
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(24));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			ex[i] = 32'h00000000;
			rd(8'(4 * i), ex[i]);
		end
		// all 32 lines of one register high at once, register by register: reserved bits must stay clear
		for (int i = 0; i < 13; i++) begin
			fire(i, 32'hFFFFFFFF);
			rd(8'(4 * i), ex[i]);
		end
		for (int i = 0; i < 13; i++) begin
			mk[i] = $urandom;
			wr(8'(4 * i) + alr_pkg::MASK_SET_BASE, mk[i]);
			rd(8'(4 * i) + alr_pkg::MASK_SET_BASE, mk[i] & msk(i));
			rd(8'(4 * i) + alr_pkg::MASKED_BASE, ex[i] & mk[i]);
			r = $urandom;
			wr(8'(4 * i) + alr_pkg::MASKED_BASE, r);
			ex[i] &= ~r;
			rd(8'(4 * i), ex[i]);
			r = $urandom;
			wr(8'(4 * i), r);
			ex[i] |= r & msk(i);
			rd(8'(4 * i), ex[i]);
			wr(8'(4 * i) + alr_pkg::MASK_CLR_BASE, mk[i]);
			rd(8'(4 * i) + alr_pkg::MASKED_BASE, 32'h00000000);
		end
		// condition held through a clear-all: held bits must survive
		@(posedge clk);
		idx <= 4'h3;
		bits <= 32'h0000FF0F;
		en <= 1'b1;
		wr(8'h0C + alr_pkg::MASKED_BASE, 32'hFFFFFFFF);
		en <= 1'b0;
		rd(8'h0C, 32'h0000FF0F & alr_pkg::RAW_B_MASK);
		// unmapped and unaligned places
		rd(8'hF4, 32'h00000000, alr_pkg::RESP_SLVERR);
		wr(8'h02, 32'hFFFFFFFF, alr_pkg::RESP_SLVERR);
		rd(8'h00, ex[0]);
		// one byte lane only: the diagnostic set must touch bits 15..8 alone
		wr(8'h30, 32'hFFFFFFFF, alr_pkg::RESP_OKAY, 4'h2);
		ex[12] |= 32'h0000FF00 & alr_pkg::SHARED_MASK;
		rd(8'h30, ex[12]);
		@(posedge clk);
		results();
	end
	// watchdog far beyond the several hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end
endmodule
